// file: operator_panel.sv
// operator push-button model for the zone test block
// assumes the bench calls hold from the core clock domain
`timescale 1ns/100ps
module operator_panel
#(
   parameter int TC = 2
)
(
   // clock
   input  wire logic core_clk,
   // buttons
   output logic      test_button,
   output logic      maint_button
);
   initial test_button = 1'b0;
   initial maint_button = 1'b0;
   // press for n ticks then let go; the operator sets the hold time
   task automatic hold(input bit m, input int n);
      @(posedge core_clk);
      if (m)
         maint_button <= 1'b1;
      else
         test_button <= 1'b1;
      repeat (n * TC) @(posedge core_clk);
      maint_button <= 1'b0;
      test_button <= 1'b0;
   endtask : hold
endmodule : operator_panel

// file: press_timer.sv
// button synchroniser with held-time measurement in ticks
// assumes a raw asynchronous button level and a one-cycle tick strobe
`timescale 1ns/100ps
module press_timer
#(
   parameter int unsigned W = 22
)
(
   // clocking
   input  wire logic          core_clk,
   input  wire logic          sys_rst,
   input  wire logic          clk_en,
   input  wire logic          tick,
   // button
   input  wire logic          button_raw,
   // results
   output logic               held,
   output logic               released,
   output logic [W-1:0]       held_ticks
);

   initial
   begin
      if (W < 2)
         $error("press_timer width too small");
   end

   logic sync_a;
   logic sync_b;

   // two stages: the first is read by nothing but the second
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end
      else if (clk_en)
      begin
         sync_a <= button_raw;
         sync_b <= sync_a;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         held <= 1'b0;
      else if (clk_en)
         held <= sync_b;
   end

   assign released = held & ~sync_b;

   // saturating count so a very long hold cannot wrap to a short one
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         held_ticks <= '0;
      else if (clk_en)
      begin
         if (!sync_b)
            held_ticks <= '0;
         else if (tick && held_ticks != {W{1'b1}})
            held_ticks <= held_ticks + W'(1);
      end
   end

endmodule : press_timer

// file: tb.sv
// self-checking bench for the zone lamp and output test block
// assumes 2 core cycles per 1 ms tick and a 2500 tick test timeout
`timescale 1ns/100ps
module tb;
   localparam int TC = 2;
   logic core_clk, sys_rst, clk_en, tbt, mbt, diag, abn, out6, nc, nh, nd, fail, need, idr, traf;
   logic [2:0] nf;
   logic pw, lk, mt, ta, co, he, da, adr, clr, rst, leave, shut, mtb;
   logic [2:0] fan;
   logic [15:0] lf;
   logic [6:0] prev, q[$];
   int miscompares, compares, nclr, nrst, cyc;
   wire [6:0] vec = {ta, fan, co, he, da};
   wire [6:0] norm = {1'b0, nf, nc, nh, nd};
   wire [2:0] lamps = {pw, lk, mt};

   initial
   begin
      core_clk = 0;
      forever #10 core_clk = ~core_clk;
   end

   operator_panel #(.TC(TC)) u_op (.core_clk(core_clk), .test_button(tbt), .maint_button(mbt));

   zone_test_led #(.TIMEOUT_TICKS(2500), .TICK_CYCLES(TC)) DUT (
      .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .test_button(tbt),
      .maint_button(mbt), .diag_active(diag), .controller_failed(fail), .restore_needed(need),
      .identify_req(idr), .net_traffic(traf), .link_abnormal(abn), .out6_is_damper(out6),
      .norm_fan(nf), .norm_cool(nc), .norm_heat(nh), .norm_damper(nd),
      .power_ok_indicator(pw), .link_activity_indicator(lk), .maintenance_alert_indicator(mt),
      .fan_speed_outputs(fan), .cooling_output(co), .heating_output(he),
      .fresh_air_damper_output(da), .test_active(ta), .min_time_bypass(mtb),
      .auto_diag_reset_en(adr), .diag_clear(clr), .controller_reset(rst),
      .network_leave(leave), .unit_shutdown(shut));

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want)
      begin
         miscompares++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check

   task automatic done(input string s);
      $display("test %s done", s);
   endtask : done

   task automatic ticks(input int n);
      repeat (n * TC) @(posedge core_clk);
   endtask : ticks

   // cycles of one whole lit phase and the dark phase after it; lamp index 2 power, 1 link, 0 maintenance
   task automatic span(input int k, output int hi, output int lo);
      hi = 0;
      lo = 0;
      while (lamps[k])
         @(posedge core_clk);
      while (!lamps[k])
         @(posedge core_clk);
      while (lamps[k])
      begin
         hi++;
         @(posedge core_clk);
      end
      while (!lamps[k])
      begin
         lo++;
         @(posedge core_clk);
      end
   endtask : span

   // lit cycles of the power lamp over one whole pattern frame; any start phase counts the same
   task automatic frame(output int n);
      n = 0;
      repeat (zone_test_pkg::PATTERN_MS * TC)
      begin
         if (pw)
            n++;
         @(posedge core_clk);
      end
   endtask : frame

   task automatic finish_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test

   // --------------------------------
   // watcher: one note per visible step change
   // --------------------------------
   initial
   begin
      logic [6:0] want;
      prev = 7'h00;
      forever
      begin
         @(posedge core_clk);
         if (!sys_rst && vec !== prev && (vec[6] | prev[6]))
         begin
            // let the pass-through outputs settle after leaving test
            repeat (3) @(posedge core_clk);
            want = q.size() ? q.pop_front() : 7'h7F;
            check(vec, want);
            check(adr, !want[6]);
            check(mtb, want[6]);
         end
         prev = vec;
      end
   end

   always @(posedge core_clk)
   begin
      cyc++;
      if (clr)
         nclr++;
      if (rst)
         nrst++;
      if (cyc == 96000)
      begin
         miscompares++;
         finish_test;
      end
   end

   // enter test with a 3000 tick hold; lamp must be dark while held
   task automatic enter;
      q.push_back(7'h40);
      fork
         u_op.hold(0, 3000);
         begin
            ticks(100);
            check(pw, 0);
         end
      join
   endtask : enter

   // --------------------------------
   // main sequence
   // --------------------------------
   initial
   begin
      logic [6:0] st[7];
      int hi, lo, n;
      sys_rst = 1;
      clk_en = 1;
      diag = 0;
      abn = 0;
      out6 = 0;
      {fail, need, idr, traf} = 4'h0;
      {nf, nc, nh, nd} = 6'h00;
      lf = 16'h0010;
      repeat (2) @(posedge core_clk);
      lf = lfsr(lf);
      sys_rst <= 0;
      {nf, nc, nh, nd, out6, diag} <= lf[7:0];
      ticks(5);
      check(pw, 1);
      check(mt, 0);
      check(lk, 0);
      u_op.hold(0, 1000);
      ticks(5);
      u_op.hold(0, 5200);
      ticks(5);
      check(ta, 0);
      done("holds");
      st = '{7'h60, 7'h50, 7'h48, 7'h64, 7'h62, {6'h30, out6}, norm};
      enter();
      ticks(5);
      frame(n);
      check(n, (diag ? 2 : 1) * zone_test_pkg::BLINK_ON_MS * TC);
      ticks(100);
      for (int i = 0; i < 7; i++)
      begin
         q.push_back(st[i]);
         u_op.hold(0, 100);
         if (i == 1)
            u_op.hold(0, 100);
         ticks(1100);
      end
      check(nclr, 2);
      check(nrst, 1);
      done("steps");
      diag <= 1;
      enter();
      q.push_back(norm);
      ticks(5);
      frame(n);
      check(n, 2 * zone_test_pkg::BLINK_ON_MS * TC);
      ticks(600);
      check(nrst, 1);
      done("timeout");
      traf <= 1;
      span(1, hi, lo);
      check(hi, zone_test_pkg::ACT_HALF_MS * TC);
      check(lo, zone_test_pkg::ACT_HALF_MS * TC);
      idr <= 1;
      ticks(1);
      idr <= 0;
      span(2, hi, lo);
      check(hi, zone_test_pkg::WINK_HALF_MS * TC);
      check(lo, zone_test_pkg::WINK_HALF_MS * TC);
      need <= 1;
      span(0, hi, lo);
      check(hi, zone_test_pkg::FLASH_PERIOD_MS * TC / 2);
      check(hi + lo, zone_test_pkg::FLASH_PERIOD_MS * TC);
      need <= 0;
      fail <= 1;
      ticks(2);
      check(mt, 1);
      fail <= 0;
      ticks(2);
      check(mt, 0);
      done("lamps");
      abn <= 1;
      ticks(2);
      check(lk, 1);
      fork
         u_op.hold(1, 15100);
         begin
            ticks(100);
            check(mt, 1);
         end
      join
      ticks(5);
      check({leave, shut}, 2'h3);
      check(q.size(), 0);
      done("maint");
      finish_test;
   end
endmodule : tb

// file: zone_test_led.sv
// lamp patterns, maintenance button handling and stepwise output test
// assumes raw buttons from pins; diagnostic, link and config levels are synchronous
`timescale 1ns/100ps
module zone_test_led
#(
   parameter int unsigned TIMEOUT_TICKS = zone_test_pkg::TEST_TIMEOUT_MS / zone_test_pkg::TICK_MS,
   parameter int unsigned TICK_CYCLES   = zone_test_pkg::TICK_CYC
)
(
   // clocking
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       clk_en,
   // operator buttons, raw pins
   input  wire logic       test_button,
   input  wire logic       maint_button,
   // controller state
   input  wire logic       diag_active,
   input  wire logic       controller_failed,
   input  wire logic       restore_needed,
   input  wire logic       identify_req,
   input  wire logic       net_traffic,
   input  wire logic       link_abnormal,
   input  wire logic       out6_is_damper,
   // normal control outputs from the regulator
   input  wire logic [2:0] norm_fan,
   input  wire logic       norm_cool,
   input  wire logic       norm_heat,
   input  wire logic       norm_damper,
   // lamps
   output logic            power_ok_indicator,
   output logic            link_activity_indicator,
   output logic            maintenance_alert_indicator,
   // unit outputs
   output logic [2:0]      fan_speed_outputs,
   output logic            cooling_output,
   output logic            heating_output,
   output logic            fresh_air_damper_output,
   // controller actions
   output logic            test_active,
   output logic            min_time_bypass,
   output logic            auto_diag_reset_en,
   output logic            diag_clear,
   output logic            controller_reset,
   output logic            network_leave,
   output logic            unit_shutdown
);

   localparam int unsigned W = zone_test_pkg::TIMER_W;
   localparam logic [W-1:0] T_MIN   = W'(zone_test_pkg::TEST_MIN_MS / zone_test_pkg::TICK_MS);
   localparam logic [W-1:0] T_MAX   = W'(zone_test_pkg::TEST_MAX_MS / zone_test_pkg::TICK_MS);
   localparam logic [W-1:0] T_SVC   = W'(zone_test_pkg::SVC_UNINST_MS / zone_test_pkg::TICK_MS);
   localparam logic [W-1:0] T_WHALF = W'(zone_test_pkg::WINK_HALF_MS / zone_test_pkg::TICK_MS);
   localparam logic [W-1:0] T_WINK  = W'(zone_test_pkg::WINK_TOTAL_MS / zone_test_pkg::TICK_MS);
   localparam logic [W-1:0] T_GAP   = W'(zone_test_pkg::STEP_GAP_MS / zone_test_pkg::TICK_MS);
   localparam logic [W-1:0] T_TOUT  = W'(TIMEOUT_TICKS);
   localparam logic [W-1:0] T_FLASH = W'(zone_test_pkg::FLASH_PERIOD_MS / zone_test_pkg::TICK_MS);
   localparam logic [W-1:0] T_BON   = W'(zone_test_pkg::BLINK_ON_MS / zone_test_pkg::TICK_MS);
   localparam logic [W-1:0] T_BSLOT = W'(zone_test_pkg::BLINK_SLOT_MS / zone_test_pkg::TICK_MS);
   localparam logic [W-1:0] T_PAT   = W'(zone_test_pkg::PATTERN_MS / zone_test_pkg::TICK_MS);
   localparam logic [W-1:0] T_ACT   = W'(zone_test_pkg::ACT_HALF_MS / zone_test_pkg::TICK_MS);

   initial
   begin
      if (TIMEOUT_TICKS < 2 || TIMEOUT_TICKS >= (1 << W) || TICK_CYCLES < 1)
         $error("zone_test_led parameters out of range");
   end

   // ----------------------------------------------------------------
   // tick and buttons
   // ----------------------------------------------------------------
   logic [31:0]  tick_cnt;
   logic         tick;
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         tick_cnt <= 32'h0;
      else if (clk_en)
         tick_cnt <= (tick_cnt >= TICK_CYCLES - 1) ? 32'h0 : tick_cnt + 32'h1;
   end
   assign tick = clk_en && (tick_cnt == 32'h0);

   logic         test_held;
   logic         test_rel;
   logic [W-1:0] test_ticks;
   logic         maint_held;
   logic [W-1:0] maint_ticks;

   press_timer #(.W(W)) u_test
   (
      .core_clk   (core_clk),
      .sys_rst    (sys_rst),
      .clk_en     (clk_en),
      .tick       (tick),
      .button_raw (test_button),
      .held       (test_held),
      .released   (test_rel),
      .held_ticks (test_ticks)
   );

   press_timer #(.W(W)) u_maint
   (
      .core_clk   (core_clk),
      .sys_rst    (sys_rst),
      .clk_en     (clk_en),
      .tick       (tick),
      .button_raw (maint_button),
      .held       (maint_held),
      .released   (),
      .held_ticks (maint_ticks)
   );

   // ----------------------------------------------------------------
   // test step sequencer
   // ----------------------------------------------------------------
   zone_test_pkg::test_step_t step;
   logic [W-1:0] step_time;
   logic         entry_ok;
   logic         adv_ok;
   logic         timeout;

   assign entry_ok = test_rel && test_ticks >= T_MIN && test_ticks <= T_MAX;
   assign adv_ok   = test_rel && step_time >= T_GAP;
   assign timeout  = step_time >= T_TOUT;

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         step <= zone_test_pkg::ST_NORMAL;
      else if (clk_en)
      begin
         case (step)
            zone_test_pkg::ST_NORMAL:
               if (entry_ok && !network_leave)
                  step <= zone_test_pkg::ST_OFF;
            zone_test_pkg::ST_EXIT:
               step <= zone_test_pkg::ST_NORMAL;
            default:
               if (timeout)
                  step <= zone_test_pkg::ST_NORMAL;
               else if (adv_ok)
                  step <= zone_test_pkg::test_step_t'(step + 4'h1);
         endcase
      end
   end

   // time spent in the current step; restarts on every advance
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         step_time <= '0;
      else if (clk_en)
      begin
         if (step == zone_test_pkg::ST_NORMAL || adv_ok)
            step_time <= '0;
         else if (tick && step_time != {W{1'b1}})
            step_time <= step_time + W'(1);
      end
   end

   // ----------------------------------------------------------------
   // unit outputs and controller actions
   // ----------------------------------------------------------------
   logic in_test;
   logic clear_due;
   assign in_test = step != zone_test_pkg::ST_NORMAL;

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         fan_speed_outputs       <= zone_test_pkg::FAN_OFF;
         cooling_output          <= 1'b0;
         heating_output          <= 1'b0;
         fresh_air_damper_output <= 1'b0;
      end
      else if (clk_en)
      begin
         fan_speed_outputs       <= zone_test_pkg::FAN_OFF;
         cooling_output          <= 1'b0;
         heating_output          <= 1'b0;
         fresh_air_damper_output <= 1'b0;
         case (step)
            zone_test_pkg::ST_NORMAL:
               if (!unit_shutdown)
               begin
                  fan_speed_outputs       <= norm_fan;
                  cooling_output          <= norm_cool;
                  heating_output          <= norm_heat;
                  fresh_air_damper_output <= norm_damper;
               end
            zone_test_pkg::ST_FAN_HI:  fan_speed_outputs <= zone_test_pkg::FAN_HIGH;
            zone_test_pkg::ST_FAN_MED: fan_speed_outputs <= zone_test_pkg::FAN_MED;
            zone_test_pkg::ST_FAN_LOW: fan_speed_outputs <= zone_test_pkg::FAN_LOW;
            zone_test_pkg::ST_COOL:
            begin
               fan_speed_outputs <= zone_test_pkg::FAN_HIGH;
               cooling_output    <= 1'b1;
            end
            zone_test_pkg::ST_HEAT:
            begin
               fan_speed_outputs <= zone_test_pkg::FAN_HIGH;
               heating_output    <= 1'b1;
            end
            zone_test_pkg::ST_DAMPER:
            begin
               fan_speed_outputs       <= zone_test_pkg::FAN_HIGH;
               fresh_air_damper_output <= out6_is_damper;
            end
            default: ;
         endcase
      end
   end

   // outputs switch straight with the step: minimum-time logic sits in the
   // regulator and is told to stand aside
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         test_active        <= 1'b0;
         min_time_bypass    <= 1'b0;
         auto_diag_reset_en <= 1'b1;
         clear_due          <= 1'b0;
         diag_clear         <= 1'b0;
         controller_reset   <= 1'b0;
      end
      else if (clk_en)
      begin
         test_active        <= in_test;
         min_time_bypass    <= in_test;
         auto_diag_reset_en <= !in_test;
         // marked on entry to ST_OFF and again on the advance out of it, not on the tick-paced step timer, so each
         // clear is one cycle whatever the tick phase; each goes out after the outputs are forced off
         clear_due          <= (step == zone_test_pkg::ST_OFF && !test_active)
                               || (step == zone_test_pkg::ST_OFF && adv_ok && !timeout);
         diag_clear         <= clear_due;
         controller_reset   <= step == zone_test_pkg::ST_EXIT;
      end
   end

   // ----------------------------------------------------------------
   // maintenance button and lamp
   // ----------------------------------------------------------------
   logic [W-1:0] flash_t;
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         flash_t <= '0;
      else if (tick)
         flash_t <= (flash_t >= T_FLASH - W'(1)) ? '0 : flash_t + W'(1);
   end

   // uninstall latches until sys_rst, as controller_reset does not clear it; holding on cannot undo it
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         network_leave <= 1'b0;
         unit_shutdown <= 1'b0;
      end
      else if (clk_en)
      begin
         if (maint_held && maint_ticks > T_SVC)
         begin
            network_leave <= 1'b1;
            unit_shutdown <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         maintenance_alert_indicator <= 1'b0;
      else if (clk_en)
      begin
         if (maint_held || controller_failed)
            maintenance_alert_indicator <= 1'b1;
         else if (restore_needed)
            maintenance_alert_indicator <= flash_t < (T_FLASH >> 1);
         else
            maintenance_alert_indicator <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // identify and power lamp
   // ----------------------------------------------------------------
   logic [W-1:0] wink_t;
   logic         wink;
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wink   <= 1'b0;
         wink_t <= '0;
      end
      else if (clk_en)
      begin
         if (identify_req)
         begin
            wink   <= 1'b1;
            wink_t <= '0;
         end
         else if (wink && tick)
         begin
            wink_t <= wink_t + W'(1);
            if (wink_t >= T_WINK - W'(1))
               wink <= 1'b0;
         end
      end
   end

   logic [W-1:0] pat_t;
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         pat_t <= '0;
      else if (tick)
         pat_t <= (pat_t >= T_PAT - W'(1)) ? '0 : pat_t + W'(1);
   end

   logic blink1;
   logic blink2;
   logic wink_on;
   assign blink1  = pat_t < T_BON;
   assign blink2  = blink1 || (pat_t >= T_BSLOT && pat_t < T_BSLOT + T_BON);
   assign wink_on = ((wink_t / T_WHALF) & W'(1)) == '0;

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         power_ok_indicator <= 1'b0;
      else if (clk_en)
      begin
         if (test_held)
            power_ok_indicator <= 1'b0;
         else if (wink)
            power_ok_indicator <= wink_on;
         else if (in_test)
            power_ok_indicator <= diag_active ? blink2 : blink1;
         else
            power_ok_indicator <= !unit_shutdown;
      end
   end

   // ----------------------------------------------------------------
   // link lamp
   // ----------------------------------------------------------------
   logic [W-1:0] act_t;
   logic         act_ph;
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         act_t  <= '0;
         act_ph <= 1'b0;
      end
      else if (tick)
      begin
         act_t <= (act_t >= T_ACT - W'(1)) ? '0 : act_t + W'(1);
         if (act_t >= T_ACT - W'(1))
            act_ph <= !act_ph;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         link_activity_indicator <= 1'b0;
      else if (clk_en)
      begin
         if (link_abnormal)
            link_activity_indicator <= 1'b1;
         else if (net_traffic)
            link_activity_indicator <= act_ph;
         else
            link_activity_indicator <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   maint_dark_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && !maint_held && !controller_failed && !restore_needed |=> !maintenance_alert_indicator)
      else $error("maintenance lamp lit in normal state");
   maint_steady_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && controller_failed |=> maintenance_alert_indicator)
      else $error("maintenance lamp dark on failure");
   uninstall_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(network_leave) |-> $past(maint_ticks) > T_SVC)
      else $error("uninstall before hold time");
   test_dark_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && test_held |=> !power_ok_indicator)
      else $error("power lamp lit while test pressed");
   link_dark_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && !net_traffic && !link_abnormal |=> !link_activity_indicator)
      else $error("link lamp lit without traffic");
   entry_window_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      step == zone_test_pkg::ST_NORMAL && clk_en && test_rel && (test_ticks < T_MIN || test_ticks > T_MAX)
      |=> step == zone_test_pkg::ST_NORMAL)
      else $error("test entered with bad hold");
   step_gap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      in_test && step != zone_test_pkg::ST_OFF && $changed(step) && step != zone_test_pkg::ST_NORMAL
      |-> $past(step_time) >= T_GAP && $past(test_rel))
      else $error("step advanced too fast or without press");
   exit_reset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && step == zone_test_pkg::ST_EXIT |=> controller_reset && step == zone_test_pkg::ST_NORMAL)
      else $error("exit step gave no reset");
   auto_reset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && in_test |=> !auto_diag_reset_en)
      else $error("auto diagnostic reset left on in test");
   damper_cfg_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && step == zone_test_pkg::ST_DAMPER && !out6_is_damper |=> !fresh_air_damper_output)
      else $error("damper energised without configuration");

endmodule : zone_test_led

// file: zone_test_pkg.sv
// constants for the zone controller lamp and output test block
// assumes a 50 MHz core clock and a slow tick derived inside the block
package zone_test_pkg;

   // clock
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned TICK_MS         = 1;
   localparam int unsigned TICK_CYC        = CLK_HZ / 1000 * TICK_MS;

   // timings in milliseconds, converted to ticks
   localparam int unsigned TEST_MIN_MS     = 2000;
   localparam int unsigned TEST_MAX_MS     = 5000;
   localparam int unsigned SVC_UNINST_MS   = 15000;
   localparam int unsigned WINK_HALF_MS    = 250;
   localparam int unsigned WINK_TOTAL_MS   = 10000;
   localparam int unsigned STEP_GAP_MS     = 1000;
   localparam int unsigned TEST_TIMEOUT_MIN = 60;
   localparam int unsigned TEST_TIMEOUT_MS = TEST_TIMEOUT_MIN * 60 * 1000;
   localparam int unsigned FLASH_PERIOD_MS = 1000;
   localparam int unsigned BLINK_ON_MS     = 200;
   localparam int unsigned BLINK_SLOT_MS   = 400;
   localparam int unsigned PATTERN_MS      = 2000;
   localparam int unsigned ACT_HALF_MS     = 100;

   localparam int unsigned TIMER_W         = 22;

   // fan speed encoding on the three fan outputs
   localparam logic [2:0] FAN_OFF          = 3'h0;
   localparam logic [2:0] FAN_HIGH         = 3'h4;
   localparam logic [2:0] FAN_MED          = 3'h2;
   localparam logic [2:0] FAN_LOW          = 3'h1;

   typedef enum logic [3:0]
   {
      ST_NORMAL  = 4'h0,
      ST_OFF     = 4'h1,
      ST_FAN_HI  = 4'h2,
      ST_FAN_MED = 4'h3,
      ST_FAN_LOW = 4'h4,
      ST_COOL    = 4'h5,
      ST_HEAT    = 4'h6,
      ST_DAMPER  = 4'h7,
      ST_EXIT    = 4'h8
   } test_step_t;

endpackage : zone_test_pkg
